// ### design/swt_sleep_timer.sv
// Sleep/wake timer: sleep clock control, wake match, remain and main counters, test mode.
//
// Contract
// - Edge polarity bit 1 of control A: set gives rising, clear gives falling interrupt.
// - Control A bit 0 set stops the sleep clock; clear runs it.
// - Control B bit 5 clear enables clock output pin; host should set it.
// - Sleep clock divided by two to the power of the 5-bit divisor.
// - 11-bit wake match compared with main counter to wake main oscillator.
// - Wake match resets to 0x00a; host never programs it below 1.
// - Writable 16-bit remain counter counts 50 ns ticks.
// - Writable 26-bit main counter in four bytes counts sleep clock periods.
// - Main and remain counters together time beacon and sleep intervals.
// - Writing 1 to main byte 3 bit 7 starts sleep; bit self-clears.
// - Signal strength wait parameter in test bits 4:3 resets to 01.
// - Test mode 111 turns the three general pins into amplifier controls.
// - Test mode 101 is single tone; 000, the default, is normal.
// - Source select 10 picks internal oscillator, 01 the external crystal.
`timescale 1ns/1ps
module swt_sleep_timer (
  // Clock, reset and clock enable
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  // Wishbone slave
  input  wire swt_pkg::swt_wb_req_t wb_i,
  output swt_pkg::swt_wb_rsp_t      wb_o,
  // Sleep clock sources and beacon timing
  input  wire logic                 osc_int_tick_i,
  input  wire logic                 osc_xtal_tick_i,
  input  wire logic                 beacon_start_i,
  // Radio activity and normal general pin drive
  input  wire logic                 tx_active_i,
  input  wire logic                 rx_active_i,
  input  wire logic [2:0]           gpio_dout_i,
  input  wire logic [2:0]           gpio_oe_n_i,
  // Interrupts
  output logic                      irq_o,
  output logic                      int_pin_o,
  // Sleep control and pins
  output logic                      osc_wake_o,
  output logic                      clock_output_pin_o,
  output logic [2:0]                gpio_o,
  output logic [2:0]                gpio_oe_n_o,
  output logic                      single_tone_o,
  output logic [1:0]                signal_strength_wait_param_o
);
  typedef struct packed {
    logic              edge_pol;
    logic              slp_dis;
    logic              clock_output_pin_dis;
    logic [4:0]        div;
    logic [10:0]       wake;
    logic [15:0]       rem;
    logic [25:0]       mainc;
    logic [1:0]        rssi;
    logic [2:0]        tm;
    logic [1:0]        src;
    logic [1:0]        status;
    logic [1:0]        mask;
    swt_pkg::swt_seq_t seq;
    logic [25:0]       main_work;
    logic [15:0]       rem_work;
    logic              ack;
    logic [7:0]        rdat;
    logic              irq;
    logic              int_pin;
    logic              osc_wake;
    logic              clock_output_pin;
    logic [2:0]        gpio;
    logic [2:0]        gpio_oe_n;
    logic              tone;
  } swt_state_t;

  localparam swt_state_t ST_RST = '{
    wake: swt_pkg::WAKE_RST,
    rssi: swt_pkg::RSSI_RST,
    tm: swt_pkg::TM_NORMAL,
    src: swt_pkg::SRC_INT,
    seq: swt_pkg::SWT_IDLE,
    int_pin: 1'b1,
    osc_wake: 1'b1,
    gpio_oe_n: 3'h7,
    default: '0
  };

  swt_state_t  q_r;
  swt_state_t  q_nxt;
  logic        sleep_tick;
  logic        rem_tick;
  logic        src_tick;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        start;
  logic [11:0] idx;
  logic [7:0]  d;
  logic [1:0]  ev;

  // The selected source is divided down; a stopped clock gives no ticks at all.
  assign src_tick = (q_r.src == swt_pkg::SRC_INT) ? osc_int_tick_i :
                    (q_r.src == swt_pkg::SRC_XTAL) ? osc_xtal_tick_i : 1'b0;

  swt_pow2_div #(
    .CNT_W (32)
  ) u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .en_i   (!q_r.slp_dis),
    .tick_i (src_tick),
    .div_i  (q_r.div),
    .tick_o (sleep_tick)
  );

  swt_tick_gen #(
    .PERIOD (swt_pkg::TICK_CYC),
    .W      (8)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .en_i   (q_r.seq == swt_pkg::SWT_REMAIN),
    .tick_o (rem_tick)
  );

  assign acc = wb_i.cyc && wb_i.stb && !q_r.ack;
  assign wr  = acc && wb_i.we && wb_i.sel[0];
  assign rd  = acc && !wb_i.we;
  assign idx = wb_i.adr[13:2];
  assign d   = wb_i.dat[7:0];

  always_comb begin
    q_nxt       = q_r;
    ev          = 2'b00;
    start       = 1'b0;
    q_nxt.ack   = acc;
    q_nxt.rdat  = 8'h00;
    // Read path; unmapped addresses still acknowledge and return zero.
    if (rd && wb_i.adr[31:14] == 18'h0) begin
      case (idx)
        swt_pkg::IDX_CTL_A:   q_nxt.rdat = {6'h00, q_r.edge_pol, q_r.slp_dis};
        swt_pkg::IDX_CTL_B:   q_nxt.rdat = {2'h0, q_r.clock_output_pin_dis, q_r.div};
        swt_pkg::IDX_WAKE_LO: q_nxt.rdat = q_r.wake[7:0];
        swt_pkg::IDX_WAKE_HI: q_nxt.rdat = {5'h00, q_r.wake[10:8]};
        swt_pkg::IDX_REM_LO:  q_nxt.rdat = q_r.rem[7:0];
        swt_pkg::IDX_REM_HI:  q_nxt.rdat = q_r.rem[15:8];
        swt_pkg::IDX_MAIN_0:  q_nxt.rdat = q_r.mainc[7:0];
        swt_pkg::IDX_MAIN_1:  q_nxt.rdat = q_r.mainc[15:8];
        swt_pkg::IDX_MAIN_2:  q_nxt.rdat = q_r.mainc[23:16];
        swt_pkg::IDX_MAIN_3:  q_nxt.rdat = {6'h00, q_r.mainc[25:24]};
        swt_pkg::IDX_TEST:    q_nxt.rdat = {3'h0, q_r.rssi, q_r.tm};
        swt_pkg::IDX_STATUS:  q_nxt.rdat = {6'h00, q_r.status};
        swt_pkg::IDX_MASK:    q_nxt.rdat = {6'h00, q_r.mask};
        swt_pkg::IDX_SRC:     q_nxt.rdat = {6'h00, q_r.src};
        default:              q_nxt.rdat = 8'h00;
      endcase
    end
    // Write path; reserved bits are dropped.
    if (wr && wb_i.adr[31:14] == 18'h0) begin
      case (idx)
        swt_pkg::IDX_CTL_A: begin
          q_nxt.edge_pol = d[swt_pkg::EDGE_BIT];
          q_nxt.slp_dis  = d[swt_pkg::SLP_DIS_BIT];
        end
        swt_pkg::IDX_CTL_B: begin
          q_nxt.clock_output_pin_dis = d[swt_pkg::CLOCK_OUTPUT_PIN_DIS_BIT];
          q_nxt.div        = d[4:0];
        end
        swt_pkg::IDX_WAKE_LO: q_nxt.wake[7:0]   = d;
        swt_pkg::IDX_WAKE_HI: q_nxt.wake[10:8]  = d[2:0];
        swt_pkg::IDX_REM_LO:  q_nxt.rem[7:0]    = d;
        swt_pkg::IDX_REM_HI:  q_nxt.rem[15:8]   = d;
        swt_pkg::IDX_MAIN_0:  q_nxt.mainc[7:0]  = d;
        swt_pkg::IDX_MAIN_1:  q_nxt.mainc[15:8] = d;
        swt_pkg::IDX_MAIN_2:  q_nxt.mainc[23:16] = d;
        swt_pkg::IDX_MAIN_3: begin
          q_nxt.mainc[25:24] = d[1:0];
          start              = d[swt_pkg::TRIG_BIT];
        end
        swt_pkg::IDX_TEST: begin
          q_nxt.rssi = d[swt_pkg::RSSI_LSB +: 2];
          q_nxt.tm   = d[2:0];
        end
        swt_pkg::IDX_MASK: q_nxt.mask = d[1:0];
        swt_pkg::IDX_SRC:  q_nxt.src  = d[1:0];
        default: begin
        end
      endcase
    end
    // Sleep sequence: main counter in sleep clock periods, then the remain counter in 50 ns ticks.
    case (q_r.seq)
      swt_pkg::SWT_IDLE: begin
      end
      swt_pkg::SWT_MAIN: begin
        if (sleep_tick) begin
          if (q_r.main_work == {15'h0000, q_r.wake}) begin
            q_nxt.osc_wake = 1'b1;
            ev[swt_pkg::ST_WAKE_BIT] = 1'b1;
          end
          if (q_r.main_work == 26'h0) begin
            q_nxt.seq = swt_pkg::SWT_REMAIN;
          end else begin
            q_nxt.main_work = q_r.main_work - 26'h1;
          end
        end
      end
      swt_pkg::SWT_REMAIN: begin
        if (rem_tick) begin
          if (q_r.rem_work == 16'h0) begin
            q_nxt.seq      = swt_pkg::SWT_IDLE;
            q_nxt.osc_wake = 1'b1;
            ev[swt_pkg::ST_DONE_BIT] = 1'b1;
          end else begin
            q_nxt.rem_work = q_r.rem_work - 16'h1;
          end
        end
      end
      default: q_nxt.seq = swt_pkg::SWT_IDLE;
    endcase
    // A software trigger or a beacon boundary restarts the interval from the programmed counts.
    if (start || beacon_start_i) begin
      q_nxt.seq       = swt_pkg::SWT_MAIN;
      q_nxt.main_work = q_nxt.mainc;
      q_nxt.rem_work  = q_nxt.rem;
      q_nxt.osc_wake  = 1'b0;
    end
    // A read clears the status, but an event in the same cycle survives it.
    if (rd && idx == swt_pkg::IDX_STATUS && wb_i.adr[31:14] == 18'h0) begin
      q_nxt.status = 2'b00;
    end
    q_nxt.status  = q_nxt.status | ev;
    q_nxt.irq     = |(q_nxt.status & q_nxt.mask);
    q_nxt.int_pin = q_nxt.edge_pol ? q_nxt.irq : !q_nxt.irq;
    // The clock output is kept for compatibility; it halts low once disabled.
    if (q_r.clock_output_pin_dis) begin
      q_nxt.clock_output_pin = 1'b0;
    end else if (sleep_tick) begin
      q_nxt.clock_output_pin = !q_r.clock_output_pin;
    end
    if (q_r.tm == swt_pkg::TM_PA_LNA) begin
      q_nxt.gpio      = {!tx_active_i, rx_active_i, tx_active_i};
      q_nxt.gpio_oe_n = 3'h0;
    end else begin
      q_nxt.gpio      = gpio_dout_i;
      q_nxt.gpio_oe_n = gpio_oe_n_i;
    end
    q_nxt.tone = (q_nxt.tm == swt_pkg::TM_TONE);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= ST_RST;
    end else if (ce_i) begin
      q_r <= q_nxt;
    end
  end

  assign wb_o                         = '{ack: q_r.ack, dat: {24'h000000, q_r.rdat}};
  assign irq_o                        = q_r.irq;
  assign int_pin_o                    = q_r.int_pin;
  assign osc_wake_o                   = q_r.osc_wake;
  assign clock_output_pin_o           = q_r.clock_output_pin;
  assign gpio_o                       = q_r.gpio;
  assign gpio_oe_n_o                  = q_r.gpio_oe_n;
  assign single_tone_o                = q_r.tone;
  assign signal_strength_wait_param_o = q_r.rssi;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_int_pin_pol: assert property (int_pin_o == (irq_o == q_r.edge_pol))
    else $error("interrupt pin polarity wrong");
  chk_slp_clk_off: assert property (ce_i && q_r.slp_dis |=> !sleep_tick)
    else $error("sleep clock ticks while disabled");
  chk_clock_output_pin_stop: assert property (ce_i && q_r.clock_output_pin_dis |=> !clock_output_pin_o)
    else $error("clock output runs while disabled");
  chk_wake_match: assert property (ce_i && q_r.seq == swt_pkg::SWT_MAIN && sleep_tick && !start
    && !beacon_start_i && q_r.main_work == {15'h0000, q_r.wake} |=> osc_wake_o)
    else $error("no wake at match");
  chk_trig_start: assert property (ce_i && start |=> q_r.seq == swt_pkg::SWT_MAIN
    && q_r.main_work == q_r.mainc && !osc_wake_o)
    else $error("trigger did not start sleep");
  chk_trig_clear: assert property (ce_i && rd && idx == swt_pkg::IDX_MAIN_3
    |=> wb_o.ack && !wb_o.dat[swt_pkg::TRIG_BIT])
    else $error("trigger bit reads back set");
  chk_rem_hold: assert property (ce_i && q_r.seq == swt_pkg::SWT_REMAIN && !rem_tick && !start
    && !beacon_start_i |=> $stable(q_r.rem_work))
    else $error("remain counter moved without tick");
  chk_done_event: assert property (ce_i && q_r.seq == swt_pkg::SWT_REMAIN && rem_tick && !start
    && !beacon_start_i && q_r.rem_work == 16'h0 |=> q_r.status[swt_pkg::ST_DONE_BIT] && osc_wake_o)
    else $error("interval end not flagged");
  chk_pa_pins: assert property (ce_i && q_r.tm == swt_pkg::TM_PA_LNA |=> gpio_oe_n_o == 3'h0
    && gpio_o[0] == $past(tx_active_i))
    else $error("amplifier pins not driven");
  chk_tone_mode: assert property (single_tone_o == (q_r.tm == swt_pkg::TM_TONE))
    else $error("single tone output mismatch");
  chk_reset_vals: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=> q_r.wake
    == swt_pkg::WAKE_RST && signal_strength_wait_param_o == swt_pkg::RSSI_RST
    && q_r.tm == swt_pkg::TM_NORMAL)
    else $error("reset values wrong");

  cov_trig_sleep: cover property (start ##[1:1000] q_r.seq == swt_pkg::SWT_REMAIN);
  cov_wake_irq: cover property (q_r.status[swt_pkg::ST_WAKE_BIT] && irq_o);
  cov_pa_mode: cover property (q_r.tm == swt_pkg::TM_PA_LNA && tx_active_i);
endmodule

// ### design/swt_pkg.sv
// Shared constants, types and register map of the sleep/wake timer.
package swt_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [11:0] IDX_CTL_A   = 12'h211;
  localparam logic [11:0] IDX_CTL_B   = 12'h220;
  localparam logic [11:0] IDX_WAKE_LO = 12'h222;
  localparam logic [11:0] IDX_WAKE_HI = 12'h223;
  localparam logic [11:0] IDX_REM_LO  = 12'h224;
  localparam logic [11:0] IDX_REM_HI  = 12'h225;
  localparam logic [11:0] IDX_MAIN_0  = 12'h226;
  localparam logic [11:0] IDX_MAIN_1  = 12'h227;
  localparam logic [11:0] IDX_MAIN_2  = 12'h228;
  localparam logic [11:0] IDX_MAIN_3  = 12'h229;
  localparam logic [11:0] IDX_TEST    = 12'h22f;
  localparam logic [11:0] IDX_STATUS  = 12'h2f0;
  localparam logic [11:0] IDX_MASK    = 12'h2f1;
  localparam logic [11:0] IDX_SRC     = 12'h2f2;
  // Field positions.
  localparam int EDGE_BIT      = 1;
  localparam int SLP_DIS_BIT   = 0;
  localparam int CLOCK_OUTPUT_PIN_DIS_BIT = 5;
  localparam int TRIG_BIT      = 7;
  localparam int RSSI_LSB      = 3;
  localparam int ST_WAKE_BIT   = 0;
  localparam int ST_DONE_BIT   = 1;
  // Reset values and encodings.
  localparam logic [10:0] WAKE_RST  = 11'h00a;
  localparam logic [1:0]  RSSI_RST  = 2'h1;
  localparam logic [2:0]  TM_NORMAL = 3'h0;
  localparam logic [2:0]  TM_TONE   = 3'h5;
  localparam logic [2:0]  TM_PA_LNA = 3'h7;
  localparam logic [1:0]  SRC_INT   = 2'h2;
  localparam logic [1:0]  SRC_XTAL  = 2'h1;
  // Timing: the remain counter advances once per 50 ns.
  localparam int TICK_NS  = 50;
  localparam int CLK_NS   = 10;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    SWT_IDLE   = 2'b00,
    SWT_MAIN   = 2'b01,
    SWT_REMAIN = 2'b10
  } swt_seq_t;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } swt_wb_req_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } swt_wb_rsp_t;
endpackage

// ### design/swt_tick_gen.sv
// Periodic one-cycle tick generator.
`timescale 1ns/1ps
module swt_tick_gen #(
  parameter int unsigned PERIOD = 5,
  parameter int unsigned W      = 8
) (
  // Clock and control
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic en_i,
  // Tick
  output logic      tick_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } swt_tg_t;
  swt_tg_t q_r;
  swt_tg_t q_nxt;

  always_comb begin
    q_nxt      = q_r;
    q_nxt.tick = 1'b0;
    if (!en_i) begin
      q_nxt.cnt = '0;
    end else if (q_r.cnt == W'(PERIOD - 1)) begin
      q_nxt.cnt  = '0;
      q_nxt.tick = 1'b1;
    end else begin
      q_nxt.cnt = q_r.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= '0;
    end else if (ce_i) begin
      q_r <= q_nxt;
    end
  end

  assign tick_o = q_r.tick;
endmodule

// ### design/swt_pow2_div.sv
// Divides a stream of source ticks by two to the power of a divisor.
`timescale 1ns/1ps
module swt_pow2_div #(
  parameter int unsigned CNT_W = 32
) (
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       en_i,
  // Ticks
  input  wire logic       tick_i,
  input  wire logic [4:0] div_i,
  output logic            tick_o
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } swt_dv_t;
  swt_dv_t          q_r;
  swt_dv_t          q_nxt;
  logic [CNT_W-1:0] limit;

  assign limit = (CNT_W'(1) << div_i) - CNT_W'(1);

  always_comb begin
    q_nxt      = q_r;
    q_nxt.tick = 1'b0;
    if (!en_i) begin
      q_nxt.cnt = '0;
    end else if (tick_i) begin
      if (q_r.cnt >= limit) begin
        q_nxt.cnt  = '0;
        q_nxt.tick = 1'b1;
      end else begin
        q_nxt.cnt = q_r.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= '0;
    end else if (ce_i) begin
      q_r <= q_nxt;
    end
  end

  assign tick_o = q_r.tick;
endmodule

// ### test/swt_host_model.sv
// Host-side model: internal sleep oscillator ticks and interrupt edge sensing.
`timescale 1ns/1ps
module swt_host_model #(
  parameter int unsigned OSC_PERIOD = 4
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Interrupt pin and the edge the host senses
  input  wire logic       int_pin_i,
  input  wire logic       edge_rise_i,
  // Oscillator tick and count of sensed edges
  output logic            osc_tick_o,
  output logic [7:0]      edge_cnt_o
);
  logic [7:0] div_r;
  logic       pin_r;

  // The internal oscillator runs free, so its tick never stops between intervals.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r      <= 8'h00;
      osc_tick_o <= 1'b0;
      pin_r      <= 1'b1;
      edge_cnt_o <= 8'h00;
    end else begin
      div_r      <= (div_r == 8'(OSC_PERIOD - 1)) ? 8'h00 : div_r + 8'h01;
      osc_tick_o <= (div_r == 8'(OSC_PERIOD - 1));
      pin_r      <= int_pin_i;
      // Only the programmed edge counts, so a polarity mismatch loses events.
      if (edge_rise_i ? (int_pin_i && !pin_r) : (!int_pin_i && pin_r)) begin
        edge_cnt_o <= edge_cnt_o + 8'h01;
      end
    end
  end
endmodule

// ### test/swt_sleep_timer_tb.sv
// Self-checking bench for the sleep/wake timer.
`timescale 1ns/1ps
module swt_sleep_timer_tb;
  logic                 clk_i;
  logic                 rst_i;
  logic                 ce;
  swt_pkg::swt_wb_req_t wb_req;
  swt_pkg::swt_wb_rsp_t wb_rsp;
  logic                 osc_tick;
  logic                 beacon_start;
  logic                 tx_act;
  logic                 rx_act;
  logic [2:0]           gpio_dout;
  logic [2:0]           gpio_oe_n;
  logic                 irq;
  logic                 int_pin;
  logic                 osc_wake;
  logic                 clk_out;
  logic [2:0]           gpio;
  logic [2:0]           gpio_oe_n_out;
  logic                 tone;
  logic [1:0]           rssi;
  logic                 edge_rise;
  logic [7:0]           edge_cnt;
  int                   error_cnt;
  int                   comparisons;
  int                   cyc_cnt;

  swt_sleep_timer i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_i(wb_req), .wb_o(wb_rsp),
    .osc_int_tick_i(osc_tick), .osc_xtal_tick_i(1'b0), .beacon_start_i(beacon_start),
    .tx_active_i(tx_act), .rx_active_i(rx_act), .gpio_dout_i(gpio_dout), .gpio_oe_n_i(gpio_oe_n),
    .irq_o(irq), .int_pin_o(int_pin), .osc_wake_o(osc_wake), .clock_output_pin_o(clk_out),
    .gpio_o(gpio), .gpio_oe_n_o(gpio_oe_n_out), .single_tone_o(tone),
    .signal_strength_wait_param_o(rssi));

  swt_host_model #(.OSC_PERIOD(4)) i_host (
    .clk_i(clk_i), .rst_i(rst_i), .int_pin_i(int_pin), .edge_rise_i(edge_rise),
    .osc_tick_o(osc_tick), .edge_cnt_o(edge_cnt));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) cyc_cnt <= cyc_cnt + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A wait that runs out of cycles is a mismatch and ends the run.
  task automatic timeout_hit();
    chk(32'h0, 32'h1);
    end_of_test();
  endtask

  // One classic cycle: request held until ack is sampled high, then released for a cycle.
  task automatic wb(input logic we, input logic [11:0] idx, input logic [7:0] wd, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {18'h0, idx, 2'b00}, sel: 4'h1, dat: {24'h0, wd}};
    do begin
      @(posedge clk_i);
      n++;
      if (n > 20) timeout_hit();
    end while (wb_rsp.ack !== 1'b1);
    rdat = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
    logic [31:0] dummy;
    wb(1'b1, idx, wd, dummy);
  endtask

  task automatic rdc(input logic [11:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    wb(1'b0, idx, 8'h00, rd);
    chk(rd, {24'h0, exp});
  endtask

  task automatic wait_hi(input bit sel_wake);
    int n;
    n = 0;
    while ((sel_wake ? osc_wake : irq) !== 1'b1) begin
      @(posedge clk_i);
      n++;
      if (n > 300) timeout_hit();
    end
  endtask

  task automatic count_tog(output int cnt);
    logic last;
    repeat (4) @(posedge clk_i);
    cnt = 0;
    last = clk_out;
    repeat (96) begin
      @(posedge clk_i);
      if (clk_out !== last) cnt++;
      last = clk_out;
    end
  endtask

  task automatic t_reset();
    chk(32'(int_pin), 32'h1);
    chk(32'(osc_wake), 32'h1);
    chk(32'(rssi), 32'h1);
    chk(32'(tone), 32'h0);
    chk(32'(gpio_oe_n_out), 32'h7);
    rdc(swt_pkg::IDX_CTL_A, 8'h00);
    rdc(swt_pkg::IDX_CTL_B, 8'h00);
    rdc(swt_pkg::IDX_WAKE_LO, 8'h0a);
    rdc(swt_pkg::IDX_WAKE_HI, 8'h00);
    rdc(swt_pkg::IDX_TEST, 8'h08);
    rdc(swt_pkg::IDX_REM_LO, 8'h00);
    rdc(swt_pkg::IDX_MAIN_3, 8'h00);
  endtask

  // Reserved bits are written high on purpose here; they must read back as zero.
  task automatic t_regs();
    logic [11:0] idx [7];
    logic [7:0]  msk [7];
    idx = '{swt_pkg::IDX_CTL_A, swt_pkg::IDX_CTL_B, swt_pkg::IDX_WAKE_HI, swt_pkg::IDX_REM_HI,
            swt_pkg::IDX_MAIN_2, swt_pkg::IDX_MAIN_0, 12'h300};
    msk = '{8'h03, 8'h3f, 8'h07, 8'hff, 8'hff, 8'hff, 8'h00};
    for (int i = 0; i < 7; i++) begin
      wr(idx[i], 8'hff);
      rdc(idx[i], msk[i]);
      wr(idx[i], 8'h00);
    end
    wr(swt_pkg::IDX_MAIN_3, 8'h03);
    rdc(swt_pkg::IDX_MAIN_3, 8'h03);
    wr(swt_pkg::IDX_MAIN_3, 8'h00);
  endtask

  task automatic t_test_mode();
    tx_act <= 1'b1;
    gpio_dout <= 3'h5;
    gpio_oe_n <= 3'h2;
    wr(swt_pkg::IDX_TEST, {3'h0, swt_pkg::RSSI_RST, swt_pkg::TM_PA_LNA});
    repeat (2) @(posedge clk_i);
    chk(32'(gpio), 32'h1);
    chk(32'(gpio_oe_n_out), 32'h0);
    tx_act <= 1'b0;
    rx_act <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(32'(gpio), 32'h6);
    wr(swt_pkg::IDX_TEST, {3'h0, 2'h2, swt_pkg::TM_TONE});
    repeat (2) @(posedge clk_i);
    chk(32'(tone), 32'h1);
    chk(32'(rssi), 32'h2);
    chk(32'(gpio_oe_n_out), 32'h2);
    wr(swt_pkg::IDX_TEST, {3'h0, swt_pkg::RSSI_RST, swt_pkg::TM_NORMAL});
    repeat (2) @(posedge clk_i);
    chk(32'(tone), 32'h0);
    chk(32'(gpio), 32'h5);
  endtask

  // Source ticks every 4 cycles; the divisor stays at 1 or more for the internal oscillator.
  task automatic t_clock_output_pin();
    int cnt;
    logic held;
    wr(swt_pkg::IDX_CTL_B, 8'h01);
    count_tog(cnt);
    chk(32'(cnt >= 11 && cnt <= 13), 32'h1);
    // A low clock enable must freeze the running clock output.
    ce <= 1'b0;
    @(posedge clk_i);
    held = clk_out;
    repeat (20) @(posedge clk_i);
    chk(32'(clk_out), 32'(held));
    ce <= 1'b1;
    wr(swt_pkg::IDX_CTL_B, 8'h03);
    count_tog(cnt);
    chk(32'(cnt >= 2 && cnt <= 4), 32'h1);
    wr(swt_pkg::IDX_CTL_B, 8'h21);
    count_tog(cnt);
    chk(32'(cnt) + 32'(clk_out), 32'h0);
    wr(swt_pkg::IDX_CTL_B, 8'h01);
    wr(swt_pkg::IDX_CTL_A, 8'h01);
    count_tog(cnt);
    chk(32'(cnt), 32'h0);
    wr(swt_pkg::IDX_CTL_A, 8'h00);
  endtask

  // Main 3 at divisor 1 gives 4 sleep ticks of 8 cycles, then 3 remain ticks of 5 cycles.
  task automatic t_sleep();
    int t0;
    logic [7:0] e0;
    wr(swt_pkg::IDX_CTL_B, 8'h21);
    wr(swt_pkg::IDX_WAKE_LO, 8'h02);
    wr(swt_pkg::IDX_MAIN_0, 8'h03);
    wr(swt_pkg::IDX_REM_LO, 8'h02);
    wr(swt_pkg::IDX_MASK, 8'h01);
    rdc(swt_pkg::IDX_STATUS, 8'h00);
    e0 = edge_cnt;
    wr(swt_pkg::IDX_MAIN_3, 8'h80);
    t0 = cyc_cnt;
    @(posedge clk_i);
    chk(32'(osc_wake), 32'h0);
    rdc(swt_pkg::IDX_MAIN_3, 8'h00);
    wait_hi(1'b0);
    repeat (3) @(posedge clk_i);
    chk(32'(osc_wake), 32'h1);
    chk(32'(int_pin), 32'h0);
    chk(32'(edge_cnt), 32'(e0 + 8'h01));
    rdc(swt_pkg::IDX_STATUS, 8'h01);
    edge_rise <= 1'b1;
    wr(swt_pkg::IDX_CTL_A, 8'h02);
    wr(swt_pkg::IDX_MASK, 8'h02);
    wait_hi(1'b0);
    // Four sleep ticks of 8 cycles with an unknown divider phase, then three 5-cycle remain ticks.
    chk(32'((cyc_cnt - t0) >= 38 && (cyc_cnt - t0) <= 50), 32'h1);
    repeat (3) @(posedge clk_i);
    chk(32'(int_pin), 32'h1);
    chk(32'(edge_cnt), 32'(e0 + 8'h02));
    rdc(swt_pkg::IDX_STATUS, 8'h02);
    wr(swt_pkg::IDX_MASK, 8'h00);
    beacon_start <= 1'b1;
    @(posedge clk_i);
    beacon_start <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(32'(osc_wake), 32'h0);
    wait_hi(1'b1);
    repeat (60) @(posedge clk_i);
    chk(32'(irq), 32'h0);
    wr(swt_pkg::IDX_MASK, 8'h02);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h1);
    rdc(swt_pkg::IDX_STATUS, 8'h03);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0);
  endtask

  initial begin
    error_cnt = 0;
    comparisons = 0;
    cyc_cnt = 0;
    rst_i = 1'b1;
    ce = 1'b1;
    wb_req = '0;
    beacon_start = 1'b0;
    tx_act = 1'b0;
    rx_act = 1'b0;
    gpio_dout = 3'h0;
    gpio_oe_n = 3'h7;
    edge_rise = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_test_mode();
    t_clock_output_pin();
    t_sleep();
    end_of_test();
  end
endmodule
